// File: include/lutiam_pkg.sv
// package of constants and carrier types for the lut index and alarm mask registers
package lutiam_pkg;
    // ----------------------------------------
    // tables and offsets
    // ----------------------------------------
    localparam logic [7:0] TABLE_LOW_ROW      = 8'h01;
    localparam logic [7:0] TABLE_HIGH_ROW     = 8'h05;
    localparam logic [7:0] TABLE_CONFIG       = 8'h02;
    localparam logic [7:0] OFF_ALARM_ENABLE_0 = 8'hFB;
    localparam logic [7:0] OFF_WARN_ENABLE_3  = 8'hFC;
    localparam logic [7:0] OFF_WARN_ENABLE_2  = 8'hFD;
    localparam logic [7:0] OFF_ROW_RSVD_LO    = 8'hFE;
    localparam logic [7:0] OFF_ROW_RSVD_HI    = 8'hFF;
    localparam logic [7:0] OFF_AUTOMATION     = 8'h80;
    localparam logic [7:0] OFF_TEMP_INDEX     = 8'h81;
    // ----------------------------------------
    // reset values and field masks
    // ----------------------------------------
    localparam logic [7:0] RST_ENABLE         = 8'h00;
    localparam logic [7:0] RST_AUTOMATION     = 8'h3F;
    localparam logic [7:0] RST_TEMP_INDEX     = 8'h00;
    localparam logic [7:0] MASK_ALARM_0       = 8'hC8;
    localparam logic [7:0] MASK_WARN_2        = 8'hF0;
    localparam logic [7:0] MASK_AUTOMATION    = 8'hBF;
    // ----------------------------------------
    // automation and alarm field positions
    // ----------------------------------------
    localparam int BIT_NV_BLOCK   = 7;
    localparam int BIT_CONV1_AUTO = 5;
    localparam int BIT_CONV2_AUTO = 4;
    localparam int BIT_INDEX_AUTO = 3;
    localparam int BIT_MOD_AUTO   = 2;
    localparam int BIT_PREF_AUTO  = 1;
    localparam int BIT_LOOP_AUTO  = 0;
    localparam int BIT_SHUT_ALARM = 3;
    // ----------------------------------------
    // index arithmetic, temperature in 1/256 degree units
    // ----------------------------------------
    localparam logic signed [15:0] TEMP_MIN    = 16'shD800;
    localparam logic signed [15:0] TEMP_MAX    = 16'sh6600;
    localparam logic signed [16:0] TEMP_OFFSET = 17'sh02800;
    localparam int                 STEP_SHIFT  = 9;
    localparam logic [7:0]         INDEX_BASE  = 8'h80;
    localparam logic [7:0]         INDEX_TOP   = 8'hC7;

    // host access carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] table_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       stop;
    } lutiam_bus_type;

    // access rights carrier
    typedef struct packed {
        logic upper_password;
        logic lower_password;
        logic enable_row_rw_permit;
        logic enable_row_ro_permit;
        logic config_tables_rw_permit;
        logic config_tables_ro_permit;
    } lutiam_rights_type;

    // monitor flag carrier
    typedef struct packed {
        logic       rx_signal_high_alarm;
        logic       rx_signal_low_alarm;
        logic       bias_max_alarm;
        logic [7:0] warn_group3;
        logic [3:0] warn_group2;
    } lutiam_flags_type;
endpackage

// File: hw/lutiam_regs.sv
// lut index and alarm mask register bank with index computation
`timescale 1ns/1ps
// Operation
// - alarm bits 7,6 gate rx-signal alarms to interrupt
// - alarm bit 3 gates bias-max to shutdown
// - warn register 3 bits gate eight warnings
// - warn register 2 bits 7:4 gate warnings
// - enable row sits in table 01h or 05h
// - enable registers power on at 00h, shadowed
// - enable row access needs upper password, or lower password and permits
// - row bytes FEh-FFh have no access
// - bit 7 blocks nonvolatile commit
// - bit 5 selects converter-1 auto or host
// - bit 4 selects converter-2 auto or host
// - bit 3 selects index auto or host
// - bit 2 selects modulation auto or host
// - bit 1 selects power reference auto or host
// - bit 0 selects feedback loop or manual bias
// - manual values apply at bus stop
// - index resets 00h, writable only manual
// - index is (temp+40)/2 plus 80h
// - index clamps to 80h and C7h
// - index addresses all lookup tables
// - lookup addresses built from index bits
// - location bit picks 01h or 05h
// - auto values refresh at conversion end
module lutiam_regs (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire lutiam_pkg::lutiam_bus_type    bus_in,
    input  wire lutiam_pkg::lutiam_rights_type rights_in,
    input  wire lutiam_pkg::lutiam_flags_type  flags_in,
    input  wire logic                        row_in_high_table_in,
    input  wire logic                        nv_restore_in,
    input  wire logic [7:0]                  nv_alarm0_in,
    input  wire logic [7:0]                  nv_warn3_in,
    input  wire logic [7:0]                  nv_warn2_in,
    input  wire logic signed [15:0]          temperature_in,
    input  wire logic                        conversion_done_in,
    output logic [7:0]                       rdata_out,
    output logic                             rvalid_out,
    output logic                             nv_commit_out,
    output logic [7:0]                       nv_commit_addr_out,
    output logic [7:0]                       nv_commit_data_out,
    output logic [7:0]                       temperature_lut_index_out,
    output logic [7:0]                       mod_lut_addr_out,
    output logic [7:0]                       table_lut_addr_out,
    output logic                             lut_recall_out,
    output logic [5:0]                       auto_modes_out,
    output logic                             manual_apply_out,
    output logic                             tx_fault_interrupt_out,
    output logic                             laser_shutdown_gate_out
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] alarm_enable_0_reg;
    logic [7:0] warning_enable_3_reg;
    logic [7:0] warning_enable_2_reg;
    logic [7:0] lut_automation_control_reg;
    logic [7:0] temperature_lut_index_reg;
    logic       manual_pending_reg;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic [7:0] row_table  = row_in_high_table_in ? lutiam_pkg::TABLE_HIGH_ROW
                                                       : lutiam_pkg::TABLE_LOW_ROW;
    wire logic in_row           = bus_in.table_sel == row_table;
    wire logic in_cfg           = bus_in.table_sel == lutiam_pkg::TABLE_CONFIG;
    wire logic row_rd_ok        = rights_in.upper_password | (rights_in.lower_password &
                                  (rights_in.enable_row_rw_permit | rights_in.enable_row_ro_permit));
    wire logic row_wr_ok        = rights_in.upper_password |
                                  (rights_in.lower_password & rights_in.enable_row_rw_permit);
    wire logic cfg_rd_ok        = rights_in.upper_password | (rights_in.lower_password &
                                  (rights_in.config_tables_rw_permit | rights_in.config_tables_ro_permit));
    wire logic cfg_wr_ok        = rights_in.upper_password |
                                  (rights_in.lower_password & rights_in.config_tables_rw_permit);
    wire logic sel_alarm0       = in_row & (bus_in.addr == lutiam_pkg::OFF_ALARM_ENABLE_0);
    wire logic sel_warn3        = in_row & (bus_in.addr == lutiam_pkg::OFF_WARN_ENABLE_3);
    wire logic sel_warn2        = in_row & (bus_in.addr == lutiam_pkg::OFF_WARN_ENABLE_2);
    wire logic sel_auto         = in_cfg & (bus_in.addr == lutiam_pkg::OFF_AUTOMATION);
    wire logic sel_index        = in_cfg & (bus_in.addr == lutiam_pkg::OFF_TEMP_INDEX);
    // reserved row bytes FEh-FFh never decode, so they are neither read nor written
    wire logic wr_row           = bus_in.wr & row_wr_ok;
    wire logic wr_alarm0        = wr_row & sel_alarm0;
    wire logic wr_warn3         = wr_row & sel_warn3;
    wire logic wr_warn2         = wr_row & sel_warn2;
    wire logic wr_auto          = bus_in.wr & cfg_wr_ok & sel_auto;
    wire logic index_auto       = lut_automation_control_reg[lutiam_pkg::BIT_INDEX_AUTO];
    wire logic wr_index         = bus_in.wr & cfg_wr_ok & sel_index & ~index_auto;
    wire logic wr_shadow        = wr_alarm0 | wr_warn3 | wr_warn2;
    wire logic nv_block         = lut_automation_control_reg[lutiam_pkg::BIT_NV_BLOCK];

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire logic [7:0] rd_mux =
        (sel_alarm0 & row_rd_ok) ? alarm_enable_0_reg :
        (sel_warn3  & row_rd_ok) ? warning_enable_3_reg :
        (sel_warn2  & row_rd_ok) ? warning_enable_2_reg :
        (sel_auto   & cfg_rd_ok) ? lut_automation_control_reg :
        (sel_index  & cfg_rd_ok) ? temperature_lut_index_reg : 8'h00;

    // ----------------------------------------
    // index computation
    // ----------------------------------------
    wire logic signed [16:0] temp_shift = 17'(temperature_in) + lutiam_pkg::TEMP_OFFSET;
    wire logic [7:0] index_raw  = 8'(temp_shift >>> lutiam_pkg::STEP_SHIFT) + lutiam_pkg::INDEX_BASE;
    wire logic [7:0] index_calc =
        (temperature_in < lutiam_pkg::TEMP_MIN) ? lutiam_pkg::INDEX_BASE :
        (temperature_in > lutiam_pkg::TEMP_MAX) ? lutiam_pkg::INDEX_TOP  : index_raw;
    wire logic [7:0] mod_addr   = {1'b1, temperature_lut_index_reg[6:0]};
    wire logic [7:0] table_addr = {2'b10, temperature_lut_index_reg[6:1]};

    // ----------------------------------------
    // interrupt and shutdown
    // ----------------------------------------
    wire logic alarm_hit = (alarm_enable_0_reg[7] & flags_in.rx_signal_high_alarm) |
                           (alarm_enable_0_reg[6] & flags_in.rx_signal_low_alarm);
    wire logic warn_hit  = |(warning_enable_3_reg & flags_in.warn_group3) |
                           |(warning_enable_2_reg[7:4] & flags_in.warn_group2);
    wire logic shut_hit  = alarm_enable_0_reg[lutiam_pkg::BIT_SHUT_ALARM] & flags_in.bias_max_alarm;

    // ----------------------------------------
    // enable row
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alarm_enable_0_reg   <= lutiam_pkg::RST_ENABLE;
            warning_enable_3_reg <= lutiam_pkg::RST_ENABLE;
            warning_enable_2_reg <= lutiam_pkg::RST_ENABLE;
        end else if (nv_restore_in) begin
            alarm_enable_0_reg   <= nv_alarm0_in & lutiam_pkg::MASK_ALARM_0;
            warning_enable_3_reg <= nv_warn3_in;
            warning_enable_2_reg <= nv_warn2_in & lutiam_pkg::MASK_WARN_2;
        end else begin
            if (wr_alarm0) alarm_enable_0_reg <= bus_in.wdata & lutiam_pkg::MASK_ALARM_0;
            if (wr_warn3) warning_enable_3_reg <= bus_in.wdata;
            if (wr_warn2) warning_enable_2_reg <= bus_in.wdata & lutiam_pkg::MASK_WARN_2;
        end
    end

    // ----------------------------------------
    // nonvolatile commit
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            nv_commit_out      <= 1'b0;
            nv_commit_addr_out <= 8'h00;
            nv_commit_data_out <= 8'h00;
        end else begin
            nv_commit_out      <= wr_shadow & ~nv_block;
            nv_commit_addr_out <= bus_in.addr;
            nv_commit_data_out <= bus_in.wdata;
        end
    end

    // ----------------------------------------
    // automation control and index
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lut_automation_control_reg <= lutiam_pkg::RST_AUTOMATION;
            temperature_lut_index_reg  <= lutiam_pkg::RST_TEMP_INDEX;
        end else begin
            if (wr_auto) lut_automation_control_reg <= bus_in.wdata & lutiam_pkg::MASK_AUTOMATION;
            if (wr_index) temperature_lut_index_reg <= bus_in.wdata;
            else if (index_auto & conversion_done_in) temperature_lut_index_reg <= index_calc;
        end
    end

    // ----------------------------------------
    // manual apply at stop, lookup recall
    // ----------------------------------------
    wire logic manual_wr = bus_in.wr & cfg_wr_ok & in_cfg & ~sel_auto & ~sel_index;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            manual_pending_reg <= 1'b0;
            manual_apply_out   <= 1'b0;
            lut_recall_out     <= 1'b0;
            mod_lut_addr_out   <= 8'h00;
            table_lut_addr_out <= 8'h00;
        end else begin
            manual_pending_reg <= bus_in.stop ? 1'b0 : (manual_pending_reg | manual_wr);
            manual_apply_out   <= bus_in.stop & (manual_pending_reg | manual_wr);
            lut_recall_out     <= conversion_done_in;
            mod_lut_addr_out   <= mod_addr;
            table_lut_addr_out <= table_addr;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out                 <= 8'h00;
            rvalid_out                <= 1'b0;
            temperature_lut_index_out <= lutiam_pkg::RST_TEMP_INDEX;
            auto_modes_out            <= lutiam_pkg::RST_AUTOMATION[5:0];
            tx_fault_interrupt_out    <= 1'b0;
            laser_shutdown_gate_out   <= 1'b0;
        end else begin
            rdata_out                 <= bus_in.rd ? rd_mux : 8'h00;
            rvalid_out                <= bus_in.rd;
            temperature_lut_index_out <= temperature_lut_index_reg;
            auto_modes_out            <= lut_automation_control_reg[5:0];
            tx_fault_interrupt_out    <= alarm_hit | warn_hit;
            laser_shutdown_gate_out   <= shut_hit;
        end
    end
endmodule // lutiam_regs

// File: dv/lutiam_regs_asserts.sv
// port-level checks of the lut index and alarm mask register bank
`timescale 1ns/1ps
module lutiam_regs_asserts (
    input wire logic                         clk_in,
    input wire logic                         rst_in,
    input wire lutiam_pkg::lutiam_bus_type   bus_in,
    input wire lutiam_pkg::lutiam_flags_type flags_in,
    input wire logic [7:0]                   rdata_out,
    input wire logic                         rvalid_out,
    input wire logic                         nv_commit_out,
    input wire logic [7:0]                   nv_commit_addr_out,
    input wire logic [7:0]                   mod_lut_addr_out,
    input wire logic [7:0]                   table_lut_addr_out,
    input wire logic                         lut_recall_out,
    input wire logic [5:0]                   auto_modes_out,
    input wire logic                         manual_apply_out,
    input wire logic                         tx_fault_interrupt_out,
    input wire logic                         laser_shutdown_gate_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_take_read;
        bus_in.rd;
    endsequence
    sequence s_gap_read;
        bus_in.rd && bus_in.addr[7:1] == 7'h7F;
    endsequence
    a_read_answer: assert property (s_take_read |=> rvalid_out)
        else $error("read not answered");
    a_gap_reads_zero: assert property (s_gap_read |=> rdata_out == 8'h00)
        else $error("reserved row byte returned data");
    a_reset_modes: assert property ($fell(rst_in) |-> auto_modes_out == 6'h3F)
        else $error("automation bits not on after reset");
    a_int_quiet: assert property (({flags_in.rx_signal_high_alarm, flags_in.rx_signal_low_alarm,
        flags_in.warn_group3, flags_in.warn_group2} == 14'h0000) |=> !tx_fault_interrupt_out)
        else $error("interrupt without a flag");
    a_shut_quiet: assert property (!flags_in.bias_max_alarm |=> !laser_shutdown_gate_out)
        else $error("shutdown without bias alarm");
    a_commit_source: assert property (nv_commit_out |-> $past(bus_in.wr)
        && nv_commit_addr_out == $past(bus_in.addr))
        else $error("commit without matching write");
    a_apply_at_stop: assert property (manual_apply_out |-> $past(bus_in.stop))
        else $error("manual apply without stop");
    a_lut_addr_form: assert property (lut_recall_out |-> mod_lut_addr_out[7]
        && table_lut_addr_out[7:6] == 2'b10)
        else $error("lookup address prefix wrong");
endmodule // lutiam_regs_asserts
bind lutiam_regs lutiam_regs_asserts i_chk (.clk_in, .rst_in, .bus_in, .flags_in, .rdata_out, .rvalid_out,
    .nv_commit_out, .nv_commit_addr_out, .mod_lut_addr_out, .table_lut_addr_out, .lut_recall_out,
    .auto_modes_out, .manual_apply_out, .tx_fault_interrupt_out, .laser_shutdown_gate_out);

// File: dv/lutiam_host.sv
// host model that issues byte accesses on the management bus
`timescale 1ns/1ps
module lutiam_host (
    input  wire logic                  clk_in,
    input  wire logic [7:0]            rdata_in,
    output lutiam_pkg::lutiam_bus_type bus_out
);
    logic [7:0] rd_data;
    initial bus_out = '0;
    task automatic access(input logic w, input logic [7:0] t, a, d);
        @(posedge clk_in);
        bus_out <= {w, ~w, t, a, d, 1'b0};
        @(posedge clk_in);
        bus_out <= {2'b00, ~t, ~a, ~d, 1'b0};
        @(negedge clk_in);
        rd_data = rdata_in;
    endtask
    task automatic stop();
        @(posedge clk_in);
        bus_out.stop <= 1'b1;
        @(posedge clk_in);
        bus_out.stop <= 1'b0;
    endtask
endmodule // lutiam_host

// File: dv/tb_top.sv
// self-checking bench for the lut index and alarm mask register bank
`timescale 1ns/1ps
module tb_top;
    logic                          clk_in, rst_in, hi_tbl, restore, conv, commit, apply, txf, shut;
    lutiam_pkg::lutiam_bus_type    bus;
    lutiam_pkg::lutiam_rights_type rights;
    lutiam_pkg::lutiam_flags_type  flags;
    logic [7:0]                    nv0, nv3, nv2, rdata, idx, maddr, taddr;
    logic signed [15:0]            temp;
    logic [5:0]                    modes;
    int                            miscompares, n_checks;
    lutiam_regs i_dut (.clk_in, .rst_in, .bus_in(bus), .rights_in(rights), .flags_in(flags),
        .row_in_high_table_in(hi_tbl), .nv_restore_in(restore), .nv_alarm0_in(nv0), .nv_warn3_in(nv3),
        .nv_warn2_in(nv2), .temperature_in(temp), .conversion_done_in(conv), .rdata_out(rdata),
        .rvalid_out(), .nv_commit_out(commit), .nv_commit_addr_out(), .nv_commit_data_out(),
        .temperature_lut_index_out(idx), .mod_lut_addr_out(maddr), .table_lut_addr_out(taddr),
        .lut_recall_out(), .auto_modes_out(modes), .manual_apply_out(apply),
        .tx_fault_interrupt_out(txf), .laser_shutdown_gate_out(shut));
    lutiam_host i_host (.clk_in, .rdata_in(rdata), .bus_out(bus));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        conclude();
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] t, a, e);
        i_host.access(1'b0, t, a, 8'h00);
        chk($sformatf("read %h/%h", t, a), e, i_host.rd_data);
    endtask
    task automatic setr(input logic [5:0] r);
        @(posedge clk_in);
        rights <= r;
    endtask
    task automatic fl(input logic [14:0] f, input logic et, es);
        @(posedge clk_in);
        flags <= f;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk("interrupt", {7'h00, et}, {7'h00, txf});
        chk("shutdown", {7'h00, es}, {7'h00, shut});
    endtask
    task automatic cv(input logic signed [15:0] t, input logic [7:0] e);
        @(posedge clk_in);
        temp <= t;
        conv <= 1'b1;
        @(posedge clk_in);
        conv <= 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk("index", e, idx);
        chk("mod address", {1'b1, e[6:0]}, maddr);
        chk("table address", {2'b10, e[6:1]}, taddr);
    endtask
    task automatic t_access();
        rd(8'h01, 8'hFB, 8'h00);
        rd(8'h01, 8'hFD, 8'h00);
        rd(8'h02, 8'h80, 8'h3F);
        rd(8'h02, 8'h81, 8'h00);
        @(posedge clk_in);
        {nv0, nv3, nv2, restore} <= {24'hFFA5FF, 1'b1};
        @(posedge clk_in);
        restore <= 1'b0;
        rd(8'h01, 8'hFB, 8'hC8);
        rd(8'h01, 8'hFC, 8'hA5);
        rd(8'h01, 8'hFD, 8'hF0);
        setr(6'h00);
        i_host.access(1'b1, 8'h01, 8'hFB, 8'h00);
        rd(8'h01, 8'hFB, 8'h00);
        setr(6'h14);
        i_host.access(1'b1, 8'h01, 8'hFB, 8'h00);
        rd(8'h01, 8'hFB, 8'hC8);
        setr(6'h18);
        i_host.access(1'b1, 8'h01, 8'hFB, 8'h40);
        rd(8'h01, 8'hFB, 8'h40);
        setr(6'h20);
        rd(8'h05, 8'hFB, 8'h00);
        @(posedge clk_in);
        hi_tbl <= 1'b1;
        rd(8'h05, 8'hFB, 8'h40);
        rd(8'h01, 8'hFB, 8'h00);
        i_host.access(1'b1, 8'h05, 8'hFF, 8'hAA);
        rd(8'h05, 8'hFF, 8'h00);
        rd(8'h05, 8'hFE, 8'h00);
        @(posedge clk_in);
        hi_tbl <= 1'b0;
        $display("test access done");
    endtask
    task automatic t_masks();
        i_host.access(1'b1, 8'h01, 8'hFB, 8'hFF);
        chk("commit", 8'h01, {7'h00, commit});
        fl(15'h4000, 1'b1, 1'b0);
        fl(15'h2000, 1'b1, 1'b0);
        fl(15'h1000, 1'b0, 1'b1);
        fl(15'h0001, 1'b1, 1'b0);
        fl(15'h0010, 1'b1, 1'b0);
        fl(15'h0020, 1'b0, 1'b0);
        i_host.access(1'b1, 8'h01, 8'hFB, 8'h08);
        fl(15'h4000, 1'b0, 1'b0);
        fl(15'h0000, 1'b0, 1'b0);
        $display("test masks done");
    endtask
    task automatic t_auto();
        i_host.access(1'b1, 8'h02, 8'h80, 8'h80);
        @(posedge clk_in);
        @(negedge clk_in);
        chk("modes", 8'h00, {2'b00, modes});
        i_host.access(1'b1, 8'h01, 8'hFB, 8'h08);
        chk("commit", 8'h00, {7'h00, commit});
        i_host.access(1'b1, 8'h02, 8'h81, 8'h5A);
        cv(16'sh1900, 8'h5A);
        i_host.access(1'b1, 8'h02, 8'h84, 8'h12);
        i_host.stop();
        @(negedge clk_in);
        chk("apply", 8'h01, {7'h00, apply});
        i_host.access(1'b1, 8'h02, 8'h80, 8'h3F);
        @(posedge clk_in);
        @(negedge clk_in);
        chk("modes", 8'h3F, {2'b00, modes});
        i_host.access(1'b1, 8'h02, 8'h81, 8'h11);
        rd(8'h02, 8'h81, 8'h5A);
        cv(16'sh1900, 8'hA0);
        cv(16'shD800, 8'h80);
        cv(16'shCE00, 8'h80);
        cv(16'sh6600, 8'hC7);
        cv(16'sh6E00, 8'hC7);
        $display("test automation done");
    endtask
    initial begin
        {rst_in, hi_tbl, restore, conv, nv0, nv3, nv2} = {4'b1000, 24'h000000};
        {temp, flags, rights, miscompares, n_checks} = {16'h0000, 15'h0000, 6'h20, 64'h0};
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        t_access();
        t_masks();
        t_auto();
        conclude();
    end
endmodule // tb_top
